/* File: logic/sst_core.sv */
`timescale 1ns/10ps
module sst_core #(
    parameter bit MAIN_EXT = 1'b1
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Instruction from decode
    input  wire logic                  op_valid,
    input  wire sst_pkg::sst_op_e      op_kind,
    input  wire logic [31:0]           op_addr,
    input  wire logic [31:0]           op_link,
    input  wire logic                  privileged,
    // Attribution lookup of op_addr
    input  wire logic                  attr_secure,
    input  wire logic                  attr_nsc,
    input  wire logic                  attr_valid,
    input  wire logic [7:0]            attr_region,
    input  wire logic                  target_is_gateway,
    // Protection lookup, current domain and Non-secure domain
    input  wire logic                  mpu_hit,
    input  wire logic [7:0]            mpu_region,
    input  wire logic                  mpu_rd_priv,
    input  wire logic                  mpu_wr_priv,
    input  wire logic                  mpu_rd_user,
    input  wire logic                  mpu_wr_user,
    input  wire logic                  ns_mpu_hit,
    input  wire logic [7:0]            ns_mpu_region,
    input  wire logic                  ns_mpu_rd_priv,
    input  wire logic                  ns_mpu_wr_priv,
    input  wire logic                  ns_mpu_rd_user,
    input  wire logic                  ns_mpu_wr_user,
    // Exceptions
    input  wire logic                  exc_req,
    input  wire logic [4:0]            exc_num,
    input  wire logic                  exc_is_fault_secure,
    input  wire logic                  exception_return_marker,
    input  wire logic                  secure_fp_used,
    input  wire logic                  handler_fp_used,
    input  wire logic [31:0]           sec_limit,
    // Results
    output      logic                  secure_state,
    output      logic [31:0]           active_sp,
    output      logic [31:0]           branch_target,
    output      logic                  branch_valid,
    output      logic [31:0]           link_out,
    output      logic                  link_load,
    output      sst_pkg::sst_fault_e   fault,
    output      sst_pkg::sst_tt_s      tt_result,
    output      logic                  tt_valid,
    output      logic                  exc_taken,
    output      logic                  exc_secure_target,
    output      logic                  bank_clear,
    output      logic                  fp_stack_skip,
    output      logic [sst_pkg::NUM_IRQ-1:0] itns_out
);
    localparam int NUM_W = sst_pkg::NUM_IRQ;

    typedef enum logic [2:0] {SST_IDLE, SST_PUSH, SST_POP, SST_CHECK} sst_state_e;

    sst_stack_if stk ();

    logic              sec_reg,        sec_next;
    logic [31:0]       ns_sp_reg;
    logic [NUM_W-1:0]  itns_reg;
    sst_state_e        st_reg;
    logic [3:0]        cnt_reg;
    logic [31:0]       frame_reg [0:7];
    logic [3:0]        frame_len_reg;
    logic              pop_exc_reg;
    logic [31:0]       ret_addr_reg;
    logic [31:0]       sec_sp;
    logic              ns_call, valid_entry, marker_ret, exc_sig_ret;
    logic [31:0]       popped_sig;

    sst_secure_stack u_stack (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .limit    (sec_limit),
        .limit_en (MAIN_EXT),
        .sp       (sec_sp),
        .port     (stk)
    );

    assign ns_call     = op_valid && !sec_reg && attr_secure
                         && (op_kind == sst_pkg::SST_OP_BRANCH || op_kind == sst_pkg::SST_OP_GATEWAY);
    assign valid_entry = target_is_gateway && attr_nsc;
    assign marker_ret  = op_valid && op_kind == sst_pkg::SST_OP_BRANCH && !sec_reg
                         && op_addr == sst_pkg::FNC_RET_MARKER && st_reg == SST_IDLE;
    assign exc_sig_ret = exception_return_marker && st_reg == SST_IDLE && frame_len_reg == sst_pkg::FRAME_WORDS;
    assign popped_sig  = stk.pop_data;

    assign secure_state = sec_reg;
    assign active_sp    = sec_reg ? sec_sp : ns_sp_reg;
    assign itns_out     = itns_reg;

    // Security state
    always_comb begin
        sec_next = sec_reg;
        if (ns_call && valid_entry) begin
            sec_next = 1'b1;
        end else if (op_valid && sec_reg
                     && (op_kind == sst_pkg::SST_OP_BRANCH_TO_NONSECURE_OP || op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP)) begin
            sec_next = op_addr[0];
        end else if (st_reg == SST_POP && cnt_reg == 4'h1 && !pop_exc_reg) begin
            sec_next = 1'b1;
        end else if (exc_req && st_reg == SST_IDLE) begin
            sec_next = !itns_reg[exc_num];
        end else if (st_reg == SST_CHECK) begin
            sec_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sec_reg <= 1'b1;
        end else begin
            sec_reg <= sec_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ns_sp_reg <= sst_pkg::SP_RESET;
        end else if (!sec_reg && exc_req && st_reg == SST_IDLE) begin
            ns_sp_reg <= ns_sp_reg - sst_pkg::WORD_STEP;
        end
    end

    // Interrupt target, only Secure writes land
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            itns_reg <= '0;
        end else if (op_valid && op_kind == sst_pkg::SST_OP_ITNS_WR && sec_reg) begin
            itns_reg <= op_addr[NUM_W-1:0];
        end
    end

    // Sequencer for Secure stacking and unstacking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg        <= SST_IDLE;
            cnt_reg       <= 4'h0;
            frame_len_reg <= 4'h0;
            pop_exc_reg   <= 1'b0;
            ret_addr_reg  <= '0;
        end else begin
            case (st_reg)
                SST_IDLE: begin
                    if (op_valid && sec_reg && op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP) begin
                        st_reg        <= SST_PUSH;
                        cnt_reg       <= sst_pkg::FNC_WORDS;
                        frame_len_reg <= sst_pkg::FNC_WORDS;
                    end else if (exc_req && sec_reg && itns_reg[exc_num]) begin
                        st_reg        <= SST_PUSH;
                        cnt_reg       <= sst_pkg::FRAME_WORDS;
                        frame_len_reg <= sst_pkg::FRAME_WORDS;
                    end else if (marker_ret) begin
                        st_reg      <= SST_POP;
                        cnt_reg     <= frame_len_reg;
                        pop_exc_reg <= 1'b0;
                    end else if (exc_sig_ret) begin
                        st_reg      <= SST_POP;
                        cnt_reg     <= frame_len_reg;
                        pop_exc_reg <= 1'b1;
                    end
                end
                SST_PUSH: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) begin
                        st_reg <= SST_IDLE;
                    end
                end
                SST_POP: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == frame_len_reg) begin
                        ret_addr_reg <= popped_sig;
                    end
                    if (cnt_reg == 4'h1) begin
                        st_reg        <= pop_exc_reg ? SST_CHECK : SST_IDLE;
                        frame_len_reg <= 4'h0;
                    end
                end
                SST_CHECK: st_reg <= SST_IDLE;
                default:   st_reg <= SST_IDLE;
            endcase
        end
    end

    // Frame contents: word 0 return address, word 1 caller state or exception number, last word signature
    always_ff @(posedge sys_clk) begin
        if (st_reg == SST_IDLE && op_valid && op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP) begin
            frame_reg[0] <= {op_link[31:1], 1'b1};
            frame_reg[1] <= {31'h0, sec_reg};
        end else if (st_reg == SST_IDLE && exc_req) begin
            frame_reg[0] <= op_link;
            frame_reg[1] <= {27'h0, exc_num};
            frame_reg[2] <= sst_pkg::FRAME_SIGNATURE;
        end
    end

    assign stk.push      = st_reg == SST_PUSH;
    assign stk.pop       = st_reg == SST_POP;
    assign stk.push_data = (cnt_reg == 4'h1 && frame_len_reg == sst_pkg::FRAME_WORDS) ? frame_reg[2]
                         : (cnt_reg == 4'h1) ? frame_reg[0] : frame_reg[1];

    // Branch and link results
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            branch_valid  <= 1'b0;
            branch_target <= '0;
            link_load     <= 1'b0;
            link_out      <= '0;
        end else begin
            branch_valid <= (ns_call && valid_entry)
                            || (op_valid && sec_reg && op_kind == sst_pkg::SST_OP_BRANCH_TO_NONSECURE_OP)
                            || (st_reg == SST_POP && cnt_reg == 4'h1 && !pop_exc_reg);
            branch_target <= (st_reg == SST_POP && cnt_reg == 4'h1) ? {ret_addr_reg[31:1], 1'b0}
                           : {op_addr[31:1], 1'b0};
            link_load <= (op_valid && sec_reg && op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP) || (ns_call && valid_entry);
            // Caller state in bit zero blocks forged Secure return addresses
            link_out  <= (op_valid && op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP) ? sst_pkg::FNC_RET_MARKER
                       : {op_link[31:1], sec_reg};
        end
    end

    // Faults
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault <= sst_pkg::SST_FLT_NONE;
        end else if (ns_call && !valid_entry) begin
            fault <= MAIN_EXT ? sst_pkg::SST_FLT_SECURE : sst_pkg::SST_FLT_HARD;
        end else if (op_valid && !sec_reg
                     && (op_kind == sst_pkg::SST_OP_TTA || op_kind == sst_pkg::SST_OP_TEST_TARGET_ALT_UNPRIV_OP)) begin
            fault <= sst_pkg::SST_FLT_UNDEF;
        end else if (st_reg == SST_CHECK && ret_addr_reg != sst_pkg::FRAME_SIGNATURE) begin
            fault <= MAIN_EXT ? sst_pkg::SST_FLT_SECURE : sst_pkg::SST_FLT_HARD;
        end else if (stk.overflow) begin
            fault <= sst_pkg::SST_FLT_SECURE;
        end else begin
            fault <= sst_pkg::SST_FLT_NONE;
        end
    end

    // Exception entry: nesting and vectoring stay with the exception unit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            exc_taken         <= 1'b0;
            exc_secure_target <= 1'b1;
            bank_clear        <= 1'b0;
            fp_stack_skip     <= 1'b0;
        end else begin
            exc_taken         <= exc_req && st_reg == SST_IDLE;
            exc_secure_target <= !itns_reg[exc_num] || exc_is_fault_secure;
            bank_clear        <= exc_req && st_reg == SST_IDLE && sec_reg && itns_reg[exc_num];
            fp_stack_skip     <= exc_req && sec_reg && itns_reg[exc_num]
                                 && secure_fp_used && !handler_fp_used;
        end
    end

    // Test target query; one region per unit assumed since regions never overlap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tt_valid  <= 1'b0;
            tt_result <= '0;
        end else begin
            tt_valid <= op_valid && op_kind inside {sst_pkg::SST_OP_TT, sst_pkg::SST_OP_TTT}
                        || (op_valid && sec_reg && op_kind inside {sst_pkg::SST_OP_TTA, sst_pkg::SST_OP_TEST_TARGET_ALT_UNPRIV_OP});
            case (op_kind)
                sst_pkg::SST_OP_TT: begin
                    tt_result.read_ok  <= mpu_hit && (privileged ? mpu_rd_priv : mpu_rd_user);
                    tt_result.write_ok <= mpu_hit && (privileged ? mpu_wr_priv : mpu_wr_user);
                end
                sst_pkg::SST_OP_TTT: begin
                    tt_result.read_ok  <= mpu_hit && mpu_rd_user;
                    tt_result.write_ok <= mpu_hit && mpu_wr_user;
                end
                sst_pkg::SST_OP_TTA: begin
                    tt_result.read_ok  <= ns_mpu_hit && (privileged ? ns_mpu_rd_priv : ns_mpu_rd_user);
                    tt_result.write_ok <= ns_mpu_hit && (privileged ? ns_mpu_wr_priv : ns_mpu_wr_user);
                end
                default: begin
                    tt_result.read_ok  <= ns_mpu_hit && ns_mpu_rd_user;
                    tt_result.write_ok <= ns_mpu_hit && ns_mpu_wr_user;
                end
            endcase
            tt_result.mpu_valid   <= (op_kind inside {sst_pkg::SST_OP_TTA, sst_pkg::SST_OP_TEST_TARGET_ALT_UNPRIV_OP}) ? ns_mpu_hit : mpu_hit;
            tt_result.mpu_region  <= (op_kind inside {sst_pkg::SST_OP_TTA, sst_pkg::SST_OP_TEST_TARGET_ALT_UNPRIV_OP}) ? ns_mpu_region
                                     : mpu_region;
            // Attribution detail hidden from Non-secure callers
            tt_result.secure      <= sec_reg && attr_secure;
            tt_result.nonsecure_callable_region         <= sec_reg && attr_nsc;
            tt_result.attr_valid  <= sec_reg && attr_valid;
            tt_result.attr_region <= sec_reg ? attr_region : 8'h00;
        end
    end

    gateway_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
        ns_call && valid_entry |=> sec_reg) else $error("Valid gateway entry did not enter Secure");
    bad_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
        ns_call && !valid_entry |=> !sec_reg && fault != sst_pkg::SST_FLT_NONE)
        else $error("Invalid entry not faulted");
    branch_to_nonsecure_op_switch_a: assert property (@(posedge sys_clk) disable iff (rst)
        op_valid && sec_reg && op_kind == sst_pkg::SST_OP_BRANCH_TO_NONSECURE_OP && !op_addr[0] |=> !sec_reg)
        else $error("Branch to Non-secure kept Secure");
    call_marker_a: assert property (@(posedge sys_clk) disable iff (rst)
        op_valid && sec_reg && op_kind == sst_pkg::SST_OP_CALL_NONSECURE_OP && st_reg == SST_IDLE
        |=> link_out == sst_pkg::FNC_RET_MARKER && link_load ##1 stk.push)
        else $error("Call did not load marker and stack");
    itns_guard_a: assert property (@(posedge sys_clk) disable iff (rst)
        op_valid && op_kind == sst_pkg::SST_OP_ITNS_WR && !sec_reg |=> $stable(itns_reg))
        else $error("Non-secure changed interrupt target");
    same_state_a: assert property (@(posedge sys_clk) disable iff (rst)
        exc_req && st_reg == SST_IDLE && !(sec_reg && itns_reg[exc_num]) |=> !bank_clear && !stk.push)
        else $error("Same-state entry stacked Secure context");
    alt_undef_a: assert property (@(posedge sys_clk) disable iff (rst)
        op_valid && !sec_reg && op_kind == sst_pkg::SST_OP_TTA |=> fault == sst_pkg::SST_FLT_UNDEF && !tt_valid)
        else $error("Alternate test target allowed from Non-secure");
    reset_secure_a: assert property (@(posedge sys_clk) $past(rst) |-> sec_reg)
        else $error("Not Secure after reset");
endmodule : sst_core

/* File: logic/sst_pkg.sv */
// Function
// - Gateway op at valid entry moves core from Non-secure to Secure
// - Non-secure call into Secure accepted only at gateway op in callable region
// - Invalid entry faults: hard fault on baseline, security fault with main extension
// - Branch-to-nonsecure op switches to Non-secure state for branch or return
// - Call-nonsecure op stacks return address and state, link gets return marker
// - Branch to return marker unstacks address and resumes caller in Secure
// - Per-interrupt target state, writable only from Secure state
// - Secure and Non-secure interrupts taken in either current state
// - Same-state exception uses ordinary entry with no extra security stacking
// - Non-secure interrupt during Secure code stacks all context and clears bank
// - Nesting, vectored fetch and vector relocation kept in both states
// - Secure FP context stacking skipped when Non-secure handler does not use FPU
// - Test target returns security state and permissions at current privilege
// - Unprivileged test target reports permissions for unprivileged access
// - Alternate-domain test targets report Non-secure access, undefined from Non-secure
// - Test target in Secure state adds attribution unit configuration
// - Result carries attributes, attribution region and protection region numbers
// - Regions never overlap, at most one match per unit
// - Main extension: Secure stack pointers have limit checks raising a fault
// - Attribution region numbers are eight bits wide
// - Separate Secure and Non-secure stack pointers selected by current state
// - Gateway entry records caller state in link bit zero, checked on return
// - Secure frame for Non-secure interrupt gets signature, checked at return
package sst_pkg;
    localparam int          ADDR_W          = 32;
    localparam int          REGION_W        = 8;
    localparam int          NUM_IRQ         = 32;
    localparam logic [31:0] FNC_RET_MARKER  = 32'hfeff_fffe;
    localparam logic [31:0] EXC_RET_BASE    = 32'hffff_ff80;
    localparam logic [31:0] FRAME_SIGNATURE = 32'hfefa_125a;
    localparam logic [31:0] SP_RESET        = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RESET     = 32'h0000_0000;
    localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
    localparam logic [3:0]  FRAME_WORDS     = 4'h8;
    localparam logic [3:0]  FNC_WORDS       = 4'h2;

    typedef enum logic [3:0] {
        SST_OP_NONE, SST_OP_BRANCH, SST_OP_GATEWAY, SST_OP_BRANCH_TO_NONSECURE_OP, SST_OP_CALL_NONSECURE_OP,
        SST_OP_TT, SST_OP_TTT, SST_OP_TTA, SST_OP_TEST_TARGET_ALT_UNPRIV_OP, SST_OP_ITNS_WR
    } sst_op_e;

    typedef enum logic [1:0] {
        SST_FLT_NONE, SST_FLT_HARD, SST_FLT_SECURE, SST_FLT_UNDEF
    } sst_fault_e;

    typedef struct packed {
        logic                read_ok;
        logic                write_ok;
        logic                secure;
        logic                nonsecure_callable_region;
        logic                attr_valid;
        logic [REGION_W-1:0] attr_region;
        logic                mpu_valid;
        logic [REGION_W-1:0] mpu_region;
    } sst_tt_s;
endpackage : sst_pkg

/* File: logic/sst_stack_if.sv */
`timescale 1ns/10ps
interface sst_stack_if;
    logic        push;
    logic        pop;
    logic [31:0] push_data;
    logic [31:0] pop_data;
    logic        overflow;
    modport ctrl  (output push, output pop, output push_data, input pop_data, input overflow);
    modport stack (input push, input pop, input push_data, output pop_data, output overflow);
endinterface : sst_stack_if

/* File: logic/sst_secure_stack.sv */
`timescale 1ns/10ps
module sst_secure_stack (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Limit and pointer
    input  wire logic [31:0] limit,
    input  wire logic        limit_en,
    output      logic [31:0] sp,
    // Word traffic
    sst_stack_if.stack       port
);
    logic [31:0] mem_reg [0:15];
    logic [31:0] sp_reg;
    logic [3:0]  idx_reg;

    assign sp = sp_reg;
    assign port.pop_data = mem_reg[idx_reg - 4'h1];
    // Stack grows down, limit violated when pushing below it
    assign port.overflow = limit_en && port.push && ((sp_reg - sst_pkg::WORD_STEP) < limit);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_reg  <= sst_pkg::SP_RESET;
            idx_reg <= 4'h0;
        end else if (port.push && !port.overflow) begin
            sp_reg  <= sp_reg - sst_pkg::WORD_STEP;
            idx_reg <= idx_reg + 4'h1;
        end else if (port.pop) begin
            sp_reg  <= sp_reg + sst_pkg::WORD_STEP;
            idx_reg <= idx_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (port.push && !port.overflow) begin
            mem_reg[idx_reg] <= port.push_data;
        end
    end

    stack_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
        port.overflow |=> sp_reg == $past(sp_reg)) else $error("Push past limit moved pointer");
endmodule : sst_secure_stack

/* File: tb/sst_core_tb.sv */
`timescale 1ns/10ps
module sst_core_tb;
    logic                sys_clk, rst, ov, pv, ats, atn, atv, gw, mh, er, ex, sf, hf;
    logic                ss, bv, ll, tv, et, es, bc, fs, a, b, c, d;
    logic [7:0]          ar;
    logic [4:0]          en;
    logic [31:0]         oa, ol, sp, bt, lo, it;
    sst_pkg::sst_op_e    ok;
    sst_pkg::sst_fault_e fl;
    sst_pkg::sst_tt_s    tr;
    int                  n_errors = 0, total_checks = 0;
    sst_core #(.MAIN_EXT(1'b1)) dut_u (.sys_clk(sys_clk), .rst(rst), .op_valid(ov), .op_kind(ok), .op_addr(oa),
        .op_link(ol), .privileged(pv), .attr_secure(ats), .attr_nsc(atn), .attr_valid(atv), .attr_region(ar),
        .target_is_gateway(gw), .mpu_hit(mh), .mpu_region(ar), .mpu_rd_priv(pv), .mpu_wr_priv(pv),
        .mpu_rd_user(pv), .mpu_wr_user(pv), .ns_mpu_hit(mh), .ns_mpu_region(ar), .ns_mpu_rd_priv(pv),
        .ns_mpu_wr_priv(pv), .ns_mpu_rd_user(pv), .ns_mpu_wr_user(pv), .exc_req(er), .exc_num(en),
        .exc_is_fault_secure(1'b0), .exception_return_marker(ex), .secure_fp_used(sf), .handler_fp_used(hf),
        .sec_limit(32'h0000_0000), .secure_state(ss), .active_sp(sp), .branch_target(bt), .branch_valid(bv),
        .link_out(lo), .link_load(ll), .fault(fl), .tt_result(tr), .tt_valid(tv), .exc_taken(et),
        .exc_secure_target(es), .bank_clear(bc), .fp_stack_skip(fs), .itns_out(it));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Entered just after an edge; one-cycle request
    task op(input sst_pkg::sst_op_e k, input logic [31:0] ad);
        ok = k;
        oa = ad;
        ov = 1'b1;
        @(posedge sys_clk) #1;
        ov = 1'b0;
        ok = sst_pkg::SST_OP_NONE;
    endtask : op
    task close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task t_tt;
        chk(ss, 1);
        ats = 1; atv = 1; ar = 8'h5a; mh = 1;
        op(sst_pkg::SST_OP_TT, 32'h1000_0000);
        chk(tv, 1);
        chk(tr.attr_region, 8'h5a);
        chk(tr.mpu_region, 8'h5a);
        chk(tr.secure, 1);
        op(sst_pkg::SST_OP_ITNS_WR, 32'h0000_0008);
        chk(it, 32'h0000_0008);
        $display("tt done");
    endtask : t_tt
    task t_call;
        ol = 32'h0000_1234; ats = 0;
        op(sst_pkg::SST_OP_CALL_NONSECURE_OP, 32'h0000_2000);
        chk(lo, sst_pkg::FNC_RET_MARKER);
        chk(ll, 1);
        chk(ss, 0);
        repeat (2) @(posedge sys_clk) #1;
        chk(sp, sst_pkg::SP_RESET);
        op(sst_pkg::SST_OP_ITNS_WR, 32'h0000_0000);
        chk(it, 32'h0000_0008);
        op(sst_pkg::SST_OP_TTA, 32'h0000_0000);
        chk(fl, sst_pkg::SST_FLT_UNDEF);
        chk(tv, 0);
        op(sst_pkg::SST_OP_BRANCH, sst_pkg::FNC_RET_MARKER);
        for (int i = 0; i < 8 && bv !== 1'b1; i++) @(posedge sys_clk) #1;
        chk(bt, 32'h0000_1234);
        chk(ss, 1);
        $display("call done");
    endtask : t_call
    // Non-secure irq 3 while Secure; Secure FP in use, handler without FP
    task t_exc;
        en = 5'h00; er = 1;
        @(posedge sys_clk) #1;
        er = 0;
        chk(et, 1);
        chk(bc, 0);
        chk(es, 1);
        chk(ss, 1);
        @(posedge sys_clk) #1;
        a = 0; b = 0; c = 0; d = 0; sf = 1; hf = 0; en = 5'h03; er = 1;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk) #1;
            if (et === 1'b1) begin a = 1; b = es; er = 0; end
            if (bc === 1'b1) c = 1;
            if (fs === 1'b1) d = 1;
        end
        chk(a, 1);
        chk(b, 0);
        chk(c, 1);
        chk(d, 1);
        er = 0; ex = 1; a = 0;
        @(posedge sys_clk) #1;
        ex = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk) #1;
            if (fl !== sst_pkg::SST_FLT_NONE) a = 1;
        end
        chk(a, 0);
        $display("exc done");
    endtask : t_exc
    task t_entry;
        op(sst_pkg::SST_OP_BRANCH_TO_NONSECURE_OP, 32'h0000_3000);
        chk(ss, 0);
        ats = 1; gw = 0; atn = 1;
        op(sst_pkg::SST_OP_BRANCH, 32'h1000_0040);
        chk(fl, sst_pkg::SST_FLT_SECURE);
        chk(ss, 0);
        gw = 1; atn = 0;
        op(sst_pkg::SST_OP_GATEWAY, 32'h1000_0040);
        chk(fl, sst_pkg::SST_FLT_SECURE);
        chk(ss, 0);
        atn = 1;
        op(sst_pkg::SST_OP_GATEWAY, 32'h1000_0040);
        chk(ss, 1);
        $display("entry done");
    endtask : t_entry
    initial begin
        rst = 1; ov = 0; ok = sst_pkg::SST_OP_NONE; oa = 0; ol = 0; pv = 1; ats = 0; atn = 0; atv = 0;
        gw = 0; mh = 0; ar = 0; er = 0; en = 0; ex = 0; sf = 0; hf = 0;
        repeat (3) @(posedge sys_clk) #1;
        rst = 0;
        t_tt();
        t_call();
        t_exc();
        t_entry();
        close_out();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
endmodule : sst_core_tb
